// file: rtl/bfc_top.v
// Summary of operation
// [RL1] bits 3:0 set converter range offset
// [RL2] bits 6:4 select preamplifier gain
// [RL3] bit 7 selects gain sign
// [RL4] bit 8 selects long or short integration
// [RL5] bit 9 enables sink during measurement
// [RL6] bits 11:10 select full or half bridge
// [RL7] bit 12 disables offset nulling
// [RL8] host keeps nulling on for gain six up
// [RL9] host preserves reserved bits 15:13
// [RL10] fields held stable during each measurement
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "bfc_defines.vh"
`default_nettype none
module bfc_top (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire measure_i,
  output reg [3:0] range_offset_o,
  output reg [2:0] gain_code_o,
  output reg gain_positive_o,
  output reg [3:0] coarse_steps_o,
  output reg [3:0] fine_steps_o,
  output reg sink_enable_o,
  output reg [1:0] input_select_o,
  output reg half_bridge_o,
  output reg nulling_off_o,
  output reg measuring_o
);
  reg [15:0] cfg_q;
  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  reg meas_q;
  reg conflict_q;
  wire [3:0] d_ofs;
  wire [2:0] d_gain;
  wire d_pol;
  wire [3:0] d_coarse;
  wire [3:0] d_fine;
  wire d_sink;
  wire [1:0] d_mux;
  wire d_half;
  wire d_null;
  wire d_high;
  wire do_write;
  wire [15:0] new_cfg;

  // reset image of the configuration word, sliced for the held offset, gain and sign outputs
  localparam [15:0] CFG_RST = `BFC_CFG_RESET;
  // bus response codes
  localparam [1:0] RESP_OKAY = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;
  // register map classes
  localparam [1:0] MAP_NONE = 2'h0;
  localparam [1:0] MAP_CFG = 2'h1;
  localparam [1:0] MAP_RO = 2'h2;

  // classifies a byte address into the register map
  function [1:0] map_kind;
    input [7:0] addr;
    begin
      if (addr == `BFC_CFG_ADDR) begin
        map_kind = MAP_CFG;
      end else if (addr == `BFC_STAT_ADDR || addr == `BFC_MEAS_ADDR) begin
        map_kind = MAP_RO;
      end else begin
        map_kind = MAP_NONE;
      end
    end
  endfunction

  // packs the read-only status word, upper bits zero
  function [31:0] status_word;
    input conflict;
    input high_gain;
    input half_bridge;
    input meas;
    input [1:0] fine_low;
    begin
      status_word = {26'h0, conflict, high_gain, half_bridge, meas, fine_low};
    end
  endfunction

  bfc_decode u_dec (
    .cfg_i(cfg_q),
    .range_offset_o(d_ofs),
    .gain_code_o(d_gain),
    .gain_positive_o(d_pol),
    .coarse_steps_o(d_coarse),
    .fine_steps_o(d_fine),
    .sink_enable_o(d_sink),
    .input_select_o(d_mux),
    .half_bridge_o(d_half),
    .nulling_off_o(d_null),
    .high_gain_o(d_high)
  );

  // write fires once address and data are both held
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  // byte-lane merge into the 16-bit word
  assign new_cfg = {wstrb_q[1] ? wdata_q[15:8] : cfg_q[15:8],
                    wstrb_q[0] ? wdata_q[7:0] : cfg_q[7:0]};

  // write channels, taken in either order
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      cfg_q <= `BFC_CFG_RESET;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (map_kind(awaddr_q) == MAP_CFG) begin
          s_axi_bresp <= RESP_OKAY;
          cfg_q <= new_cfg; // [RL10]
        end else if (map_kind(awaddr_q) == MAP_RO) begin
          s_axi_bresp <= RESP_OKAY; // read-only, write ignored
        end else begin
          s_axi_bresp <= RESP_SLVERR; // unmapped: slverr
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          `BFC_CFG_ADDR: s_axi_rdata <= {16'h0000, cfg_q};
          `BFC_STAT_ADDR: s_axi_rdata <= status_word(conflict_q, d_high, d_half, meas_q,
                                                     d_fine[1:0]);
          `BFC_MEAS_ADDR: s_axi_rdata <= {24'h000000, range_offset_o, coarse_steps_o};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR; // unmapped
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // measurement phase: latch fields at its start, hold them throughout
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meas_q <= 1'b0;
      measuring_o <= 1'b0;
      range_offset_o <= CFG_RST[`BFC_OFS_MSB:`BFC_OFS_LSB];
      gain_code_o <= CFG_RST[`BFC_GAIN_MSB:`BFC_GAIN_LSB];
      gain_positive_o <= CFG_RST[`BFC_POL_BIT];
      coarse_steps_o <= `BFC_LONG_COARSE;
      fine_steps_o <= `BFC_LONG_FINE;
      sink_enable_o <= 1'b0;
      input_select_o <= `BFC_MUX_FULL;
      half_bridge_o <= 1'b0;
      nulling_off_o <= 1'b0;
      conflict_q <= 1'b0;
    end else begin
      meas_q <= measure_i;
      measuring_o <= measure_i;
      sink_enable_o <= measure_i && (meas_q ? sink_enable_o : d_sink); // [RL5]
      if (!meas_q) begin // [RL10]
        range_offset_o <= d_ofs; // [RL1]
        gain_code_o <= d_gain; // [RL2]
        gain_positive_o <= d_pol; // [RL3]
        coarse_steps_o <= d_coarse; // [RL4]
        fine_steps_o <= d_fine; // [RL4]
        input_select_o <= d_mux; // [RL6]
        half_bridge_o <= d_half; // [RL6]
        nulling_off_o <= d_null; // [RL7]
      end
      // flags host setting that breaks nulling guidance
      conflict_q <= d_null && d_high; // [RL8]
    end
  end
endmodule
`default_nettype wire

// file: rtl/bfc_defines.vh
`ifndef BFC_DEFINES_VH
`define BFC_DEFINES_VH
// register index and byte address (index 0x0F, four bytes a word)
`define BFC_CFG_IDX 8'h0F
`define BFC_CFG_ADDR 8'h3C
`define BFC_STAT_ADDR 8'h40
`define BFC_MEAS_ADDR 8'h44
// field positions
`define BFC_OFS_LSB 0
`define BFC_OFS_MSB 3
`define BFC_GAIN_LSB 4
`define BFC_GAIN_MSB 6
`define BFC_POL_BIT 7
`define BFC_LONG_BIT 8
`define BFC_SINK_BIT 9
`define BFC_MUX_LSB 10
`define BFC_MUX_MSB 11
`define BFC_NULL_BIT 12
`define BFC_RSV_LSB 13
`define BFC_RSV_MSB 15
// reset value of the configuration word
`define BFC_CFG_RESET 16'h0BA8
// integration step counts
`define BFC_LONG_COARSE 4'hB
`define BFC_LONG_FINE 4'h3
`define BFC_SHORT_COARSE 4'h9
`define BFC_SHORT_FINE 4'h5
// mux codes
`define BFC_MUX_FULL 2'h2
`define BFC_MUX_HALF 2'h3
// gain codes at or above 6
`define BFC_GAIN_6 3'h1
`endif

// file: rtl/bfc_decode.v
`include "bfc_defines.vh"
`default_nettype none
// splits the configuration word into front-end control fields
module bfc_decode (
  input wire [15:0] cfg_i,
  output wire [3:0] range_offset_o,
  output wire [2:0] gain_code_o,
  output wire gain_positive_o,
  output wire [3:0] coarse_steps_o,
  output wire [3:0] fine_steps_o,
  output wire sink_enable_o,
  output wire [1:0] input_select_o,
  output wire half_bridge_o,
  output wire nulling_off_o,
  output wire high_gain_o
);
  assign range_offset_o = cfg_i[`BFC_OFS_MSB:`BFC_OFS_LSB]; // [RL1]
  assign gain_code_o = cfg_i[`BFC_GAIN_MSB:`BFC_GAIN_LSB]; // [RL2]
  assign gain_positive_o = cfg_i[`BFC_POL_BIT]; // [RL3]
  // integration length
  assign coarse_steps_o = cfg_i[`BFC_LONG_BIT] ? `BFC_LONG_COARSE : `BFC_SHORT_COARSE; // [RL4]
  assign fine_steps_o = cfg_i[`BFC_LONG_BIT] ? `BFC_LONG_FINE : `BFC_SHORT_FINE; // [RL4]
  assign sink_enable_o = cfg_i[`BFC_SINK_BIT];
  assign input_select_o = cfg_i[`BFC_MUX_MSB:`BFC_MUX_LSB]; // [RL6]
  assign half_bridge_o = (input_select_o == `BFC_MUX_HALF); // [RL6]
  assign nulling_off_o = cfg_i[`BFC_NULL_BIT]; // [RL7]
  // gain 6 and above: codes other than 000 and 100
  assign high_gain_o = (gain_code_o[1:0] != 2'h0); // [RL8]
endmodule
`default_nettype wire

// file: tb/bfc_asserts.sv
`default_nettype none
// watches the front-end control outputs of the top
module bfc_asserts (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic measure_i,
  input wire logic measuring_o,
  input wire logic sink_enable_o,
  input wire logic [3:0] coarse_steps_o,
  input wire logic [3:0] fine_steps_o,
  input wire logic [1:0] input_select_o,
  input wire logic half_bridge_o,
  input wire logic [2:0] gain_code_o,
  input wire logic [3:0] range_offset_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // measurement phase tracking and field relations
  a_meas_rise: assert property (measure_i |=> measuring_o)
    else $error("measuring flag did not follow request");
  a_meas_fall: assert property (!measure_i |=> !measuring_o)
    else $error("measuring flag stayed up");
  a_sink_meas: assert property (sink_enable_o |-> measuring_o)
    else $error("sink enabled outside measurement");
  a_step_long: assert property (coarse_steps_o == 4'hB |-> fine_steps_o == 4'h3)
    else $error("long integration fine count wrong");
  a_step_short: assert property (coarse_steps_o != 4'hB |->
    coarse_steps_o == 4'h9 && fine_steps_o == 4'h5)
    else $error("short integration counts wrong");
  a_half_sel: assert property (half_bridge_o == (input_select_o == 2'h3))
    else $error("half bridge flag disagrees with select");
  a_fields_frozen: assert property (measuring_o && $past(measuring_o) |->
    $stable({range_offset_o, gain_code_o, input_select_o, coarse_steps_o}))
    else $error("fields changed during measurement");
  a_sink_stable: assert property (measuring_o && $past(measuring_o) |->
    $stable(sink_enable_o))
    else $error("sink changed during measurement");
endmodule
bind bfc_top bfc_asserts u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .measure_i(measure_i),
  .measuring_o(measuring_o), .sink_enable_o(sink_enable_o), .coarse_steps_o(coarse_steps_o),
  .fine_steps_o(fine_steps_o), .input_select_o(input_select_o), .half_bridge_o(half_bridge_o),
  .gain_code_o(gain_code_o), .range_offset_o(range_offset_o));
`default_nettype wire

// file: tb/tb.sv
`include "bfc_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, measure_i = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h00000000, rd;
  logic [3:0] ws = 4'h0;
  logic [15:0] w;
  logic [20:0] e;
  logic [1:0] rsp;
  wire awr, wrd, bv, arr, rv, pol, snk, hlf, nul, msr;
  wire [1:0] br, rr, sel;
  wire [31:0] rdat;
  wire [3:0] ofs, crs, fin;
  wire [2:0] gn;
  wire [20:0] flds = {ofs, gn, pol, crs, fin, sel, hlf, nul, snk};
  integer miscompares = 0, checked = 0, i;
  bfc_top dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .measure_i(measure_i),
    .range_offset_o(ofs), .gain_code_o(gn), .gain_positive_o(pol), .coarse_steps_o(crs),
    .fine_steps_o(fin), .sink_enable_o(snk), .input_select_o(sel), .half_bridge_o(hlf),
    .nulling_off_o(nul), .measuring_o(msr));
  // clock, 100 ns period
  always #50 clk_sys_i = ~clk_sys_i;
  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // bus write, address and data offered together
  task axw(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (awv || wv) begin
      @(posedge clk_sys_i);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    do @(posedge clk_sys_i); while (!bv);
    rsp = br;
    bre <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task axr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk_sys_i); while (!arr);
    arv <= 1'b0;
    do @(posedge clk_sys_i); while (!rv);
    rd = rdat;
    rsp = rr;
    rre <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk_sys_i);
    miscompares++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    axr(`BFC_CFG_ADDR);
    chk(rd, 32'h00000BA8);
    chk(flds, {4'h8, 3'h2, 1'b1, 4'hB, 4'h3, 2'h2, 3'h0});
    // every offset and gain code, both mux codes, upper lanes junk
    for (i = 0; i < 16; i++) begin
      w = {3'h0, ~|i[1:0], 1'b1, i[1], 1'b1, i[2], i[1], i[2:0], i[3:0]};
      axw(`BFC_CFG_ADDR, {16'hA5A5, w});
      axr(`BFC_CFG_ADDR);
      chk(rd, {16'h0000, w});
      e = {i[3:0], i[2:0], i[1], i[2] ? 8'hB3 : 8'h95, 1'b1, i[1], i[1], ~|i[1:0], 1'b0};
      chk(flds, e);
    end
    // fields hold while measuring, new word lands afterwards
    measure_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk(snk, 1'b1);
    chk(msr, 1'b1);
    axr(`BFC_STAT_ADDR);
    chk(rd, 32'h0000001F);
    axw(`BFC_CFG_ADDR, 32'h00000C00);
    chk(flds, {4'hF, 3'h7, 1'b1, 4'hB, 4'h3, 2'h3, 3'h5});
    axr(`BFC_MEAS_ADDR);
    chk(rd, 32'h000000FB);
    measure_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk(flds, {4'h0, 3'h0, 1'b0, 4'h9, 4'h5, 2'h3, 3'h4});
    chk(msr, 1'b0);
    measure_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk(snk, 1'b0);
    measure_i <= 1'b0;
    // unmapped and read-only places
    axw(8'h80, 32'h00000000);
    chk(rsp, 2'h2);
    axr(8'h80);
    chk(rsp, 2'h2);
    chk(rd, 32'h00000000);
    axw(`BFC_STAT_ADDR, 32'hFFFFFFFF);
    chk(rsp, 2'h0);
    axr(`BFC_CFG_ADDR);
    chk(rd, 32'h00000C00);
    // nulling off at gain six on purpose, to raise the host warning flag
    axw(`BFC_CFG_ADDR, 32'h00001813);
    axr(`BFC_STAT_ADDR);
    chk(rd, 32'h00000031);
    axr(`BFC_MEAS_ADDR);
    chk(rd, 32'h00000039);
    chk({nul, pol, gn}, {1'b1, 1'b0, 3'h1});
    report_and_stop();
  end
endmodule
`default_nettype wire
